/* logic/pmr_accum.sv */
// running accumulator with overflow detection, signed or unsigned
`default_nettype none
module pmr_accum #(
   parameter int W = 40,
   parameter bit SIGNED_ACC = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clear,
   input wire logic add_en,
   input wire logic [W-1:0] add_val,
   output logic [W-1:0] acc_r,
   output logic ovf_r
);
   logic [W-1:0] acc_nxt;
   logic ovf_nxt;
   logic [W:0] sum;

   always_comb begin
      sum = {1'b0, acc_r} + {1'b0, add_val};
      acc_nxt = acc_r;
      ovf_nxt = 1'b0;
      // clear takes precedence, so a stale sample never lands after a reset
      if (clear) begin
         acc_nxt = '0;
      end else if (add_en) begin
         acc_nxt = sum[W-1:0];
         if (SIGNED_ACC) begin
            ovf_nxt = (acc_r[W-1] == add_val[W-1]) && (sum[W-1] != acc_r[W-1]);
         end else begin
            ovf_nxt = sum[W];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_r <= '0;
         ovf_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         ovf_r <= ovf_nxt;
      end
   end
endmodule // pmr_accum
`default_nettype wire

/* logic/pmr_result_regs.sv */
// measurement setup and result register bank of the power monitor
`default_nettype none
module pmr_result_regs #(
   parameter pmr_pkg::pmr_tab_t CONV_CYC = pmr_pkg::CONV_CYC_DEF,
   parameter int POWER_SHIFT = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_rd_en,
   input wire logic reg_wr_en,
   input wire logic [pmr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pmr_pkg::REG_W-1:0] reg_wr_data,
   input wire logic [pmr_pkg::MEAS_W-1:0] adc_bus_v,
   input wire logic [pmr_pkg::MEAS_W-1:0] adc_current,
   input wire logic [pmr_pkg::TEMP_W-1:0] adc_temp,
   output logic [pmr_pkg::RD_W-1:0] reg_rd_data_r,
   output logic sample_take_r,
   output logic result_update_r
);
   import pmr_pkg::*;

   // -----------------------------------------------------------------
   // setup and control writes
   // -----------------------------------------------------------------
   logic [CT_W-1:0] shunt_ct_r, shunt_ct_nxt;
   logic [CT_W-1:0] temp_ct_r, temp_ct_nxt;
   logic [CT_W-1:0] avg_sel_r, avg_sel_nxt;
   logic acc_clear_r, acc_clear_nxt;

   always_comb begin
      shunt_ct_nxt = shunt_ct_r;
      temp_ct_nxt = temp_ct_r;
      avg_sel_nxt = avg_sel_r;
      acc_clear_nxt = 1'b0;
      if (reg_wr_en && reg_addr == ADDR_SETUP) begin
         shunt_ct_nxt = reg_wr_data[SETUP_SHUNT_LSB +: CT_W];
         temp_ct_nxt = reg_wr_data[SETUP_TEMP_LSB +: CT_W];
         avg_sel_nxt = reg_wr_data[SETUP_AVG_LSB +: CT_W];
      end
      // clear is a one-cycle pulse; the bit itself never reads back as set
      if (reg_wr_en && reg_addr == ADDR_CTRL) begin
         acc_clear_nxt = reg_wr_data[CTRL_ACC_CLR_BIT];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shunt_ct_r <= SHUNT_CT_RST;
         temp_ct_r <= TEMP_CT_RST;
         avg_sel_r <= AVG_RST;
         acc_clear_r <= 1'b0;
      end else begin
         shunt_ct_r <= shunt_ct_nxt;
         temp_ct_r <= temp_ct_nxt;
         avg_sel_r <= avg_sel_nxt;
         acc_clear_r <= acc_clear_nxt;
      end
   end

   // -----------------------------------------------------------------
   // conversion sequencer and averaging
   // -----------------------------------------------------------------
   pmr_state_t state_r, state_nxt;
   logic [TMR_W-1:0] tmr_r, tmr_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic signed [SUM_W-1:0] sum_v_r, sum_v_nxt;
   logic signed [SUM_W-1:0] sum_i_r, sum_i_nxt;
   logic signed [SUM_W-1:0] sum_t_r, sum_t_nxt;
   logic sample_take_nxt;
   logic [TMR_W-1:0] conv_len;
   logic [CNT_W-1:0] avg_count;
   logic [SH_W-1:0] avg_sh;

   always_comb begin
      // total time of one cycle is shunt plus temperature time
      conv_len = TMR_W'(CONV_CYC[shunt_ct_r]) + TMR_W'(CONV_CYC[temp_ct_r]);
      avg_sh = pmr_avg_shift(avg_sel_r);
      avg_count = CNT_W'(1) << avg_sh;
      state_nxt = state_r;
      tmr_nxt = tmr_r;
      cnt_nxt = cnt_r;
      sum_v_nxt = sum_v_r;
      sum_i_nxt = sum_i_r;
      sum_t_nxt = sum_t_r;
      sample_take_nxt = 1'b0;
      case (state_r)
         ST_CONVERT: begin
            if (tmr_r + TMR_W'(1) >= conv_len) begin
               tmr_nxt = '0;
               sample_take_nxt = 1'b1;
               sum_v_nxt = sum_v_r + SUM_W'(signed'(adc_bus_v));
               sum_i_nxt = sum_i_r + SUM_W'(signed'(adc_current));
               sum_t_nxt = sum_t_r + SUM_W'(signed'(adc_temp));
               cnt_nxt = cnt_r + CNT_W'(1);
               // publish only once the whole sample set is in
               if (cnt_r + CNT_W'(1) >= avg_count) begin
                  state_nxt = ST_PUBLISH;
               end
            end else begin
               tmr_nxt = tmr_r + TMR_W'(1);
            end
         end
         ST_PUBLISH: begin
            cnt_nxt = '0;
            sum_v_nxt = '0;
            sum_i_nxt = '0;
            sum_t_nxt = '0;
            state_nxt = ST_POWER;
         end
         ST_POWER: state_nxt = ST_ACCUM;
         ST_ACCUM: state_nxt = ST_CONVERT;
         default: state_nxt = ST_CONVERT;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r <= ST_CONVERT;
         tmr_r <= '0;
         cnt_r <= '0;
         sum_v_r <= '0;
         sum_i_r <= '0;
         sum_t_r <= '0;
         sample_take_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tmr_r <= tmr_nxt;
         cnt_r <= cnt_nxt;
         sum_v_r <= sum_v_nxt;
         sum_i_r <= sum_i_nxt;
         sum_t_r <= sum_t_nxt;
         sample_take_r <= sample_take_nxt;
      end
   end

   // -----------------------------------------------------------------
   // result registers
   // -----------------------------------------------------------------
   logic [MEAS_W-1:0] bus_v_r, bus_v_nxt;
   logic [TEMP_W-1:0] temp_r, temp_nxt;
   logic [MEAS_W-1:0] curr_r, curr_nxt;
   logic [PWR_W-1:0] pwr_r, pwr_nxt;
   logic result_update_nxt;
   logic signed [SUM_W-1:0] avg_v, avg_i, avg_t;
   logic [MEAS_W-1:0] curr_mag;
   logic [2*MEAS_W-1:0] pwr_full;

   always_comb begin
      avg_v = sum_v_r >>> avg_sh;
      avg_i = sum_i_r >>> avg_sh;
      avg_t = sum_t_r >>> avg_sh;
      curr_mag = curr_r[MEAS_W-1] ? MEAS_W'(-curr_r) : curr_r;
      // bus voltage never goes negative, so its magnitude is the raw code
      pwr_full = (2*MEAS_W)'(curr_mag) * (2*MEAS_W)'(bus_v_r);
      bus_v_nxt = bus_v_r;
      temp_nxt = temp_r;
      curr_nxt = curr_r;
      pwr_nxt = pwr_r;
      result_update_nxt = 1'b0;
      if (state_r == ST_PUBLISH) begin
         bus_v_nxt = avg_v[MEAS_W-1:0];
         curr_nxt = avg_i[MEAS_W-1:0];
         temp_nxt = avg_t[TEMP_W-1:0];
      end
      if (state_r == ST_POWER) begin
         pwr_nxt = PWR_W'(pwr_full >> POWER_SHIFT);
         result_update_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bus_v_r <= '0;
         temp_r <= '0;
         curr_r <= '0;
         pwr_r <= '0;
         result_update_r <= 1'b0;
      end else begin
         bus_v_r <= bus_v_nxt;
         temp_r <= temp_nxt;
         curr_r <= curr_nxt;
         pwr_r <= pwr_nxt;
         result_update_r <= result_update_nxt;
      end
   end

   // -----------------------------------------------------------------
   // energy and charge accumulators
   // -----------------------------------------------------------------
   logic acc_add;
   logic [ACC_W-1:0] energy_acc, charge_acc;
   logic energy_ovf, charge_ovf;
   logic [ACC_W-1:0] pwr_ext, curr_ext;

   assign acc_add = (state_r == ST_ACCUM);
   assign pwr_ext = ACC_W'(pwr_r);
   assign curr_ext = ACC_W'(signed'(curr_r));

   pmr_accum #(
      .W(ACC_W),
      .SIGNED_ACC(1'b0)
   ) u_energy (
      .clk_sys(clk_sys),
      .rst(rst),
      .clear(acc_clear_r),
      .add_en(acc_add),
      .add_val(pwr_ext),
      .acc_r(energy_acc),
      .ovf_r(energy_ovf)
   );

   pmr_accum #(
      .W(ACC_W),
      .SIGNED_ACC(1'b1)
   ) u_charge (
      .clk_sys(clk_sys),
      .rst(rst),
      .clear(acc_clear_r),
      .add_en(acc_add),
      .add_val(curr_ext),
      .acc_r(charge_acc),
      .ovf_r(charge_ovf)
   );

   // -----------------------------------------------------------------
   // diagnostic flags
   // -----------------------------------------------------------------
   logic eof_r, eof_nxt;
   logic cof_r, cof_nxt;
   logic done_r, done_nxt;
   logic diag_rd;

   always_comb begin
      diag_rd = reg_rd_en && reg_addr == ADDR_DIAG;
      // a set arriving with its clear is kept
      eof_nxt = energy_ovf | (eof_r & ~acc_clear_r);
      cof_nxt = charge_ovf | (cof_r & ~acc_clear_r);
      done_nxt = result_update_r | (done_r & ~diag_rd);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         eof_r <= DIAG_RST[DIAG_EOF_BIT];
         cof_r <= DIAG_RST[DIAG_COF_BIT];
         done_r <= DIAG_RST[DIAG_DONE_BIT];
      end else begin
         eof_r <= eof_nxt;
         cof_r <= cof_nxt;
         done_r <= done_nxt;
      end
   end

   // -----------------------------------------------------------------
   // read-back
   // -----------------------------------------------------------------
   logic [RD_W-1:0] rd_nxt;
   logic [REG_W-1:0] diag_word;
   logic [REG_W-1:0] setup_word;

   always_comb begin
      diag_word = DIAG_RST;
      diag_word[DIAG_EOF_BIT] = eof_r;
      diag_word[DIAG_COF_BIT] = cof_r;
      diag_word[DIAG_DONE_BIT] = done_r;
      setup_word = '0;
      setup_word[SETUP_SHUNT_LSB +: CT_W] = shunt_ct_r;
      setup_word[SETUP_TEMP_LSB +: CT_W] = temp_ct_r;
      setup_word[SETUP_AVG_LSB +: CT_W] = avg_sel_r;
      rd_nxt = reg_rd_data_r;
      if (reg_rd_en) begin
         case (reg_addr)
            ADDR_SETUP: rd_nxt = RD_W'(setup_word);
            ADDR_BUS_V: rd_nxt = RD_W'({bus_v_r, RSV_W'(0)});
            ADDR_TEMP: rd_nxt = RD_W'(temp_r);
            ADDR_CURR: rd_nxt = RD_W'({curr_r, RSV_W'(0)});
            ADDR_PWR: rd_nxt = RD_W'(pwr_r);
            ADDR_ENERGY: rd_nxt = energy_acc;
            ADDR_CHARGE: rd_nxt = charge_acc;
            ADDR_DIAG: rd_nxt = RD_W'(diag_word);
            default: rd_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rd_data_r <= '0;
      end else begin
         reg_rd_data_r <= rd_nxt;
      end
   end
endmodule // pmr_result_regs
`default_nettype wire

/* pkg/pmr_pkg.sv */
// shared constants, tables and types of the power monitor result bank
`default_nettype none
package pmr_pkg;

   // -----------------------------------------------------------------
   // clock and conversion timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned HZ_PER_MHZ = 1_000_000;
   localparam int unsigned CT_CODES = 8;
   typedef int unsigned pmr_tab_t [CT_CODES];
   // conversion times in microseconds, indexed by the 3-bit code
   localparam pmr_tab_t CONV_US = '{50, 84, 150, 280, 540, 1052, 2074, 4120};

   function automatic pmr_tab_t pmr_conv_table();
      pmr_tab_t t;
      for (int i = 0; i < CT_CODES; i++) begin
         t[i] = CONV_US[i] * (CLK_HZ / HZ_PER_MHZ);
         if (t[i] < 1) begin
            t[i] = 1;
         end
      end
      return t;
   endfunction

   localparam pmr_tab_t CONV_CYC_DEF = pmr_conv_table();
   localparam int TMR_W = 17;

   // -----------------------------------------------------------------
   // register addresses
   // -----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_SETUP = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_BUS_V = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_TEMP = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_CURR = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_PWR = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_ENERGY = 4'h9;
   localparam logic [ADDR_W-1:0] ADDR_CHARGE = 4'hA;
   localparam logic [ADDR_W-1:0] ADDR_DIAG = 4'hB;

   // -----------------------------------------------------------------
   // field layout and reset values
   // -----------------------------------------------------------------
   localparam int REG_W = 16;
   localparam int RD_W = 40;
   localparam int CT_W = 3;
   localparam int SETUP_SHUNT_LSB = 6;
   localparam int SETUP_TEMP_LSB = 3;
   localparam int SETUP_AVG_LSB = 0;
   localparam logic [CT_W-1:0] SHUNT_CT_RST = 3'h5;
   localparam logic [CT_W-1:0] TEMP_CT_RST = 3'h5;
   localparam logic [CT_W-1:0] AVG_RST = 3'h0;
   localparam int CTRL_ACC_CLR_BIT = 14;
   localparam logic [REG_W-1:0] DIAG_RST = 16'h0001;
   localparam int DIAG_EOF_BIT = 11;
   localparam int DIAG_COF_BIT = 10;
   localparam int DIAG_DONE_BIT = 1;
   localparam int DIAG_BASE_BIT = 0;

   localparam int MEAS_W = 20;
   localparam int TEMP_W = 16;
   localparam int PWR_W = 24;
   localparam int ACC_W = 40;
   localparam int RSV_W = 4;
   localparam int AVG_MAX_LOG = 10;
   localparam int SUM_W = MEAS_W + AVG_MAX_LOG;
   localparam int CNT_W = AVG_MAX_LOG + 1;
   localparam int SH_W = 4;

   // log2 of the averaging count for each code
   function automatic logic [SH_W-1:0] pmr_avg_shift(input logic [CT_W-1:0] code);
      case (code)
         3'h0: return 4'h0;
         3'h1: return 4'h2;
         3'h2: return 4'h4;
         3'h3: return 4'h6;
         3'h4: return 4'h7;
         3'h5: return 4'h8;
         3'h6: return 4'h9;
         default: return 4'hA;
      endcase
   endfunction

   typedef enum logic [1:0] {
      ST_CONVERT,
      ST_PUBLISH,
      ST_POWER,
      ST_ACCUM
   } pmr_state_t;

endpackage
`default_nettype wire

/* test/pmr_host_model.sv */
// host-side register access model for the result bank
`default_nettype none
module pmr_host_model (
   input wire logic clk_sys,
   input wire logic [pmr_pkg::RD_W-1:0] reg_rd_data_r,
   output var logic reg_rd_en,
   output var logic reg_wr_en,
   output var logic [pmr_pkg::ADDR_W-1:0] reg_addr,
   output var logic [pmr_pkg::REG_W-1:0] reg_wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   import pmr_pkg::*;
   initial begin
      reg_rd_en = 1'b0;
      reg_wr_en = 1'b0;
      reg_addr = 4'hF;
      reg_wr_data = 16'h0000;
   end
   // an idle cycle follows every strobe, so no strobe falls and rises in one step
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [RD_W-1:0] d);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(posedge clk_sys);
      #1;
      d = reg_rd_data_r;
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] v);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wr_data = v;
      @(posedge clk_sys);
      #1;
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wr_data = ~v;
      @(posedge clk_sys);
      #1;
   endtask
endmodule // pmr_host_model
`default_nettype wire

/* test/pmr_result_regs_sva.sv */
// port-level checker of the result bank
`default_nettype none
module pmr_result_regs_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_rd_en,
   input wire logic reg_wr_en,
   input wire logic [pmr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pmr_pkg::REG_W-1:0] reg_wr_data,
   input wire logic [pmr_pkg::RD_W-1:0] reg_rd_data_r,
   input wire logic sample_take_r,
   input wire logic result_update_r
);
   timeunit 1ns;
   timeprecision 1ns;
   import pmr_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // the take pulse leads the power update by two edges
   chk_upd_after_take: assert property (result_update_r |-> $past(sample_take_r, 2))
      else $error("update without a sample just before");
   chk_diag_word: assert property (reg_rd_en && reg_addr == ADDR_DIAG |=>
      reg_rd_data_r[0] && reg_rd_data_r[39:12] == '0 && reg_rd_data_r[9:2] == '0)
      else $error("diag word malformed");
   chk_busv_low: assert property (reg_rd_en && reg_addr == ADDR_BUS_V |=>
      reg_rd_data_r[3:0] == 4'h0 && reg_rd_data_r[39:23] == '0)
      else $error("bus voltage low or high bits set");
   chk_curr_low: assert property (reg_rd_en && reg_addr == ADDR_CURR |=>
      reg_rd_data_r[3:0] == 4'h0 && reg_rd_data_r[39:24] == '0)
      else $error("current low or high bits set");
   chk_temp_width: assert property (reg_rd_en && reg_addr == ADDR_TEMP |=>
      reg_rd_data_r[39:16] == '0)
      else $error("temperature wider than 16 bits");
   chk_pwr_width: assert property (reg_rd_en && reg_addr == ADDR_PWR |=>
      reg_rd_data_r[39:24] == '0)
      else $error("power wider than 24 bits");
   chk_setup_readback: assert property (reg_wr_en && reg_addr == ADDR_SETUP ##2
      reg_rd_en && reg_addr == ADDR_SETUP |=>
      reg_rd_data_r == {31'h0, $past(reg_wr_data[8:0], 3)})
      else $error("setup readback differs from write");
   chk_done_set: assert property (result_update_r ##2
      reg_rd_en && reg_addr == ADDR_DIAG |=> reg_rd_data_r[DIAG_DONE_BIT])
      else $error("conversion done flag not set");
endmodule // pmr_result_regs_chk
bind pmr_result_regs pmr_result_regs_chk i_chk (.clk_sys(clk_sys), .rst(rst),
   .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
   .reg_wr_data(reg_wr_data), .reg_rd_data_r(reg_rd_data_r),
   .sample_take_r(sample_take_r), .result_update_r(result_update_r));
`default_nettype wire

/* test/testbench.sv */
// self-checking bench of the power monitor result bank
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pmr_pkg::*;
   // short conversion counts keep the run small
   localparam pmr_tab_t CYC = '{2, 3, 4, 5, 6, 7, 8, 9};
   localparam int SH [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
   localparam int PSH = 16;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic reg_rd_en, reg_wr_en, sample_take_r, result_update_r;
   logic [ADDR_W-1:0] reg_addr;
   logic [REG_W-1:0] reg_wr_data;
   logic [MEAS_W-1:0] adc_bus_v = '0, adc_current = '0;
   logic [TEMP_W-1:0] adc_temp = '0;
   logic [RD_W-1:0] reg_rd_data_r;
   int failures = 0, cmp_count = 0, n_take = 0, n_cyc = 0;
   pmr_host_model i_pmr_host_model (.clk_sys(clk_sys), .reg_rd_data_r(reg_rd_data_r),
      .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data));
   pmr_result_regs #(.CONV_CYC(CYC), .POWER_SHIFT(PSH)) i_pmr_result_regs (
      .clk_sys(clk_sys), .rst(rst), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
      .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .adc_bus_v(adc_bus_v),
      .adc_current(adc_current), .adc_temp(adc_temp), .reg_rd_data_r(reg_rd_data_r),
      .sample_take_r(sample_take_r), .result_update_r(result_update_r));
   initial forever #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      n_cyc++;
      if (sample_take_r === 1'b1) n_take++;
   end
   task automatic chk(input logic [RD_W-1:0] got, input logic [RD_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   task automatic wt_upd();
      for (int k = 0; k < 20000 && result_update_r !== 1'b1; k++) cyc(1);
      // a wait that runs out is a mismatch of its own
      if (result_update_r !== 1'b1) failures++;
   endtask
   // cycles between two updates; a fixed pipeline offset cancels in differences
   task automatic per(output int p);
      int c0;
      wt_upd();
      c0 = n_cyc;
      cyc(1);
      wt_upd();
      p = n_cyc - c0;
   endtask
   initial begin
      logic [RD_W-1:0] d;
      logic [MEAS_W-1:0] vb, cu;
      int p0, p, n0, k;
      longint cs, pw;
      k = $urandom(32'h23770bc8);
      repeat (16) @(posedge clk_sys);
      #1 rst = 1'b0;
      for (k = 5; k <= 10; k++) begin
         i_pmr_host_model.rd(4'(k), d);
         chk(d, '0);
      end
      i_pmr_host_model.rd(ADDR_DIAG, d);
      chk(d, 40'h1);
      i_pmr_host_model.rd(ADDR_SETUP, d);
      chk(d, 40'h168);
      i_pmr_host_model.rd(4'h3, d);
      chk(d, '0);
      i_pmr_host_model.wr(ADDR_SETUP, 16'hFFFF);
      i_pmr_host_model.rd(ADDR_SETUP, d);
      chk(d, 40'h1FF);
      i_pmr_host_model.wr(ADDR_SETUP, 16'h0168);
      per(p0);
      per(p0);
      for (k = 0; k < 8; k++) begin
         // pairing shifted by three; steps 5 to 7 repeat the summed lengths of steps 1 to 3
         i_pmr_host_model.wr(ADDR_SETUP, 16'((k << 6) | (((k + 3) % 8) << 3)));
         per(p);
         per(p);
         chk(40'(p - p0), 40'(int'(CYC[k] + CYC[(k + 3) % 8]) - 2 * int'(CYC[5])));
      end
      for (k = 0; k < 8; k++) begin
         i_pmr_host_model.wr(ADDR_SETUP, 16'(k));
         wt_upd();
         n0 = n_take;
         cyc(1);
         wt_upd();
         chk(40'(n_take - n0), 40'(1 << SH[k]));
      end
      vb = 20'($urandom) & 20'h7FFFF;
      cu = 20'($urandom);
      adc_bus_v = vb;
      adc_current = cu;
      adc_temp = 16'($urandom);
      i_pmr_host_model.wr(ADDR_SETUP, 16'h01F8);
      wt_upd();
      cyc(1);
      wt_upd();
      cyc(2);
      i_pmr_host_model.wr(ADDR_CTRL, 16'h4000);
      repeat (3) begin
         cyc(1);
         wt_upd();
      end
      cyc(2);
      cs = longint'($signed(cu));
      pw = (((cs < 0) ? -cs : cs) * longint'(vb) >> PSH) & 64'hFFFFFF;
      i_pmr_host_model.rd(ADDR_BUS_V, d);
      chk(d, 40'({vb, 4'h0}));
      i_pmr_host_model.rd(ADDR_TEMP, d);
      chk(d, 40'(adc_temp));
      i_pmr_host_model.rd(ADDR_CURR, d);
      chk(d, 40'({cu, 4'h0}));
      i_pmr_host_model.rd(ADDR_PWR, d);
      chk(d, 40'(pw));
      i_pmr_host_model.rd(ADDR_ENERGY, d);
      chk(d, 40'(3 * pw));
      i_pmr_host_model.rd(ADDR_CHARGE, d);
      chk(d, 40'(3 * cs));
      i_pmr_host_model.rd(ADDR_DIAG, d);
      chk(d & 40'hC01, 40'h1);
      // result registers ignore writes
      i_pmr_host_model.wr(ADDR_PWR, 16'hFFFF);
      i_pmr_host_model.rd(ADDR_PWR, d);
      chk(d, 40'(pw));
      wt_upd();
      cyc(2);
      i_pmr_host_model.rd(ADDR_DIAG, d);
      chk(40'(d[DIAG_DONE_BIT]), 40'h1);
      i_pmr_host_model.rd(ADDR_DIAG, d);
      chk(40'(d[DIAG_DONE_BIT]), 40'h0);
      wrap_up();
   end
   initial begin
      #5_000_000;
      failures++;
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
